// [core/fsl_erase.sv]
`timescale 1ns/1ps
module fsl_erase
  import fsl_pkg::*;
#(
  parameter int EVENTS = ERASE_EVENTS_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  fsl_erase_if.eng eif
);
  logic half_ff;
  logic [2:0] pre_ff;
  logic [5:0] div_cnt_ff;
  logic [15:0] ev_ff;
  logic busy_ff;
  logic done_ff;
  logic pre_wrap;
  logic div_wrap;

  // flash input clock is half the system clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= ~half_ff;
    end
  end

  assign pre_wrap = !eif.div[6] || pre_ff == 3'h7;
  assign div_wrap = div_cnt_ff == eif.div[5:0];
  assign eif.tick = busy_ff && half_ff && pre_wrap && div_wrap;

  // prescale then divide by divisor plus one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_ff <= 3'h0;
      div_cnt_ff <= 6'h00;
    end else if (!busy_ff) begin
      pre_ff <= 3'h0;
      div_cnt_ff <= 6'h00;
    end else if (half_ff) begin
      pre_ff <= pre_wrap ? 3'h0 : pre_ff + 3'h1;
      if (pre_wrap) begin
        div_cnt_ff <= div_wrap ? 6'h00 : div_cnt_ff + 6'h01;
      end
    end
  end

  // mass erase runs for a fixed count of timed events
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      ev_ff <= 16'h0000;
    end else if (eif.start) begin
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
      ev_ff <= 16'h0000;
    end else if (busy_ff && eif.abort) begin
      busy_ff <= 1'b0;
    end else if (eif.tick) begin
      ev_ff <= ev_ff + 16'h0001;
      if (ev_ff == 16'(EVENTS - 1)) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end
    end
  end

  assign eif.busy = busy_ff;
  assign eif.done = done_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_erase_start: assert property (eif.start |=> eif.busy && !eif.done)
    else $error("erase did not start");
  c_erase_done: cover property ($rose(eif.done));
endmodule // fsl_erase

// [core/fsl_erase_if.sv]
`timescale 1ns/1ps
// recovery control between tap side and erase timing engine
interface fsl_erase_if;
  logic start;
  logic abort;
  logic [6:0] div;
  logic busy;
  logic done;
  logic tick;
  modport ctl (output start, abort, div, input busy, done, tick);
  modport eng (input start, abort, div, output busy, done, tick);
endinterface

// [core/fsl_pkg.sv]
package fsl_pkg;
  // register map, byte addresses on the apb bus
  localparam logic [11:0] REG_TIMING_DIV = 12'h000;
  localparam logic [11:0] REG_SEC_STATUS = 12'h004;
  localparam logic [11:0] REG_BACKDOOR = 12'h008;
  localparam logic [6:0] TIMING_DIV_RST = 7'h00;
  // status register bit positions
  localparam int ST_SECURED = 0;
  localparam int ST_KEY_EN = 1;
  localparam int ST_BOOT_INT = 2;
  localparam int ST_DBG_DIS = 3;
  localparam int ST_REC_BUSY = 4;
  localparam int ST_REC_DONE = 5;
  localparam int ST_BD_OPEN = 6;
  // security byte decode: low byte pattern locks, high byte bit enables the key
  localparam logic [7:0] SEC_ON_CODE = 8'h5a;
  localparam int KEY_EN_BIT = 7;
  localparam logic [23:0] BOOT_FLASH_ADDR = 24'h020000;
  localparam logic [23:0] EXT_BOOT_ADDR = 24'h000000;
  // reset release windows, clock cycles each
  localparam logic [6:0] STAGE_LEN = 7'h20;
  localparam logic [6:0] SEQ_END = 7'h60;
  // tap instruction codes
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_SAMPLE = 4'h3;
  localparam logic [3:0] IR_LOCKOUT = 4'h5;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [31:0] ID_CODE = 32'h00001001; // arbitrary value
  localparam int ERASE_EVENTS_DEF = 4000;
  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } fsl_tap_t;
endpackage

// [core/fsl_rst_seq.sv]
`timescale 1ns/1ps
module fsl_rst_seq
  import fsl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  output logic periph_run,
  output logic sec_sample,
  output logic core_run
);
  logic meta_ff;
  logic sync_ff;
  logic [6:0] cnt_ff;

  // reset asserts at once but releases on a clock edge only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= 1'b1;
      sync_ff <= meta_ff;
    end
  end

  // a 32 cycle clock window, a 64 cycle peripheral window with security, then core
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 7'h00;
    end else if (sync_ff && cnt_ff != SEQ_END) begin
      cnt_ff <= cnt_ff + 7'h01;
    end
  end

  assign sec_sample = sync_ff && (cnt_ff == STAGE_LEN);
  assign periph_run = cnt_ff >= STAGE_LEN;
  assign core_run = cnt_ff == SEQ_END;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_seq_windows: assert property (sec_sample |-> ##64 core_run)
    else $error("core released off the window");
endmodule // fsl_rst_seq

// [core/fsl_top.sv]
`timescale 1ns/1ps
// Function
// - security from two nonvolatile bytes, persists
// - secured blocks external program space and debug
// - secured boots internally at boot flash address
// - secured ignores external boot select pin
// - debug read disable follows security bytes
// - tap always active, scan and id
// - recovery mass erase clears security (here only timed; SECURED holds until the next reset samples the bytes)
// - recovery instruction has 7-bit divider register
// - jtag divider replaces flash timing divider
// - top bit prescale, low six divisor
// - input is half clock, divide by div+1
// - entering run-test/idle starts the erase
// - backdoor key only when key enabled
// - execution otherwise unaffected by security
// - async assert, clocked release, security window
module fsl_top
  import fsl_pkg::*;
#(
  parameter int ERASE_EVENTS = ERASE_EVENTS_DEF
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] SEC_BYTE_LO,
  input wire logic [7:0] SEC_BYTE_HI,
  input wire logic [31:0] KEY_WORD,
  input wire logic EXTERNAL_BOOT_SELECT,
  input wire logic TRST_B,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  input wire logic [7:0] BSCAN_IN,
  output logic SECURED,
  output logic BOOT_INTERNAL,
  output logic [23:0] BOOT_ADDR,
  output logic EXT_PSPACE_EN,
  output logic DEBUG_READ_DIS,
  output logic BACKDOOR_OPEN,
  output logic PERIPH_RUN,
  output logic CORE_RUN,
  output logic PRESCALE_BY_EIGHT,
  output logic [5:0] FLASH_DIVISOR,
  output logic MASS_ERASE,
  output logic ERASE_TICK
);
  fsl_erase_if eif ();
  logic sec_sample;
  fsl_tap_t tap_ff;
  fsl_tap_t nxt_tap;
  logic tck_q_ff;
  logic tck_rise;
  logic tck_fall;
  logic [3:0] ir_sh_ff;
  logic [3:0] ir_ff;
  logic [31:0] dr_sh_ff;
  logic [6:0] div_ff;
  logic div_valid_ff;
  logic tdo_ff;
  logic tdo_oe_ff;
  logic rec_active_ff;
  logic [6:0] timing_div_ff;
  logic [6:0] eff_div_ff;
  logic [6:0] nxt_eff_div;
  logic sec_ff;
  logic key_en_ff;
  logic ext_boot_ff;
  logic bd_open_ff;
  logic [31:0] prdata_ff;
  logic err_ff;
  logic setup;
  logic wr_acc;
  logic rti_enter;

  function automatic logic is_secured(input logic [7:0] lo);
    return lo == SEC_ON_CODE;
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    return a == REG_TIMING_DIV || a == REG_SEC_STATUS || a == REG_BACKDOOR;
  endfunction

  function automatic fsl_tap_t tap_next(input fsl_tap_t s, input logic m);
    unique case (s)
      TAP_TLR: return m ? TAP_TLR : TAP_RTI;
      TAP_RTI: return m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: return m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: return m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: return m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: return m ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: return m ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: return m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: return m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: return m ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: return m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: return m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: return m ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: return m ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: return m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: return m ? TAP_SEL_DR : TAP_RTI;
    endcase
  endfunction

  // shift length follows the selected data register
  function automatic logic [31:0] dr_shift(input logic [31:0] sh, input logic d,
                                           input logic [3:0] ir);
    unique case (ir)
      IR_IDCODE: return {d, sh[31:1]};
      IR_LOCKOUT: return {25'h0, d, sh[6:1]};
      IR_SAMPLE: return {24'h0, d, sh[7:1]};
      default: return {31'h0, d};
    endcase
  endfunction

  fsl_rst_seq u_rst_seq (
    .clk(CLOCK),
    .rst_b(RST_B),
    .periph_run(PERIPH_RUN),
    .sec_sample(sec_sample),
    .core_run(CORE_RUN)
  );

  fsl_erase #(.EVENTS(ERASE_EVENTS)) u_erase (
    .clk(CLOCK),
    .rst_b(RST_B),
    .eif(eif.eng)
  );

  // security bytes are sampled once, in the peripheral release window
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      sec_ff <= 1'b1; // locked until the bytes have been read
      key_en_ff <= 1'b0;
      ext_boot_ff <= 1'b0;
    end else if (sec_sample) begin
      sec_ff <= is_secured(SEC_BYTE_LO);
      key_en_ff <= SEC_BYTE_HI[KEY_EN_BIT];
      ext_boot_ff <= EXTERNAL_BOOT_SELECT && !is_secured(SEC_BYTE_LO);
    end
  end

  // boot mode and access gates; these and the backdoor key compare are all that differ when secured
  assign SECURED = sec_ff;
  assign DEBUG_READ_DIS = sec_ff;
  assign EXT_PSPACE_EN = ext_boot_ff;
  assign BOOT_INTERNAL = !ext_boot_ff;
  assign BOOT_ADDR = ext_boot_ff ? EXT_BOOT_ADDR : BOOT_FLASH_ADDR;

  // tck is slow and synchronous to the clock, so edges are found by compare
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tck_q_ff <= 1'b1; // tck idles high, so no false rise right after reset
    end else begin
      tck_q_ff <= TCK;
    end
  end

  assign tck_rise = TCK && !tck_q_ff;
  assign tck_fall = !TCK && tck_q_ff;
  assign nxt_tap = tap_next(tap_ff, TMS);

  // tap runs whatever the security state is
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tap_ff <= TAP_TLR;
    end else if (!TRST_B) begin
      tap_ff <= TAP_TLR;
    end else if (tck_rise) begin
      tap_ff <= nxt_tap;
    end
  end

  // instruction register, id code selected after tap reset
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ir_sh_ff <= IR_CAPTURE;
      ir_ff <= IR_IDCODE;
    end else if (!TRST_B || tap_ff == TAP_TLR) begin
      ir_ff <= IR_IDCODE;
    end else if (tck_rise) begin
      unique case (tap_ff)
        TAP_CAP_IR: ir_sh_ff <= IR_CAPTURE;
        TAP_SH_IR: ir_sh_ff <= {TDI, ir_sh_ff[3:1]};
        TAP_UPD_IR: ir_ff <= ir_sh_ff;
        default: ir_sh_ff <= ir_sh_ff;
      endcase
    end
  end

  // data shift path: id, boundary sample, divider or bypass
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      dr_sh_ff <= 32'h0;
    end else if (tck_rise && tap_ff == TAP_CAP_DR) begin
      unique case (ir_ff)
        IR_IDCODE: dr_sh_ff <= ID_CODE;
        IR_SAMPLE: dr_sh_ff <= {24'h0, BSCAN_IN};
        IR_LOCKOUT: dr_sh_ff <= {25'h0, div_ff};
        default: dr_sh_ff <= 32'h0;
      endcase
    end else if (tck_rise && tap_ff == TAP_SH_DR) begin
      dr_sh_ff <= dr_shift(dr_sh_ff, TDI, ir_ff);
    end
  end

  // divider is taken only on update with the recovery instruction; it is loaded
  // while the tap sits in update-dr, so it is already valid at the rise into idle
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      div_ff <= 7'h00;
      div_valid_ff <= 1'b0;
    end else if (!TRST_B) begin
      div_valid_ff <= 1'b0;
    end else if (tap_ff == TAP_UPD_DR && ir_ff == IR_LOCKOUT) begin
      div_ff <= dr_sh_ff[6:0];
      div_valid_ff <= 1'b1;
    end
  end

  // tdo changes on the falling tck edge and floats outside shift states
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (tck_fall) begin
      tdo_ff <= (tap_ff == TAP_SH_IR) ? ir_sh_ff[0] : dr_sh_ff[0];
      tdo_oe_ff <= tap_ff == TAP_SH_IR || tap_ff == TAP_SH_DR;
    end
  end

  assign TDO = tdo_ff;
  assign TDO_OE = tdo_oe_ff;

  // erase starts on entry to run-test/idle, never without a divider
  assign rti_enter = tck_rise && nxt_tap == TAP_RTI && tap_ff != TAP_RTI && TRST_B;
  assign eif.start = rti_enter && ir_ff == IR_LOCKOUT && div_valid_ff
                     && !eif.busy;
  assign eif.abort = tap_ff != TAP_RTI; // leaving idle early kills the erase
  assign eif.div = eff_div_ff;

  // override stays until trst is asserted, as the host must do anyway
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rec_active_ff <= 1'b0;
    end else if (eif.start) begin
      rec_active_ff <= 1'b1;
    end else if (!TRST_B) begin
      rec_active_ff <= 1'b0;
    end
  end

  assign nxt_eff_div = rec_active_ff || eif.start ? div_ff : timing_div_ff;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      eff_div_ff <= TIMING_DIV_RST;
    end else begin
      eff_div_ff <= nxt_eff_div;
    end
  end

  assign PRESCALE_BY_EIGHT = eff_div_ff[6];
  assign FLASH_DIVISOR = eff_div_ff[5:0];
  assign MASS_ERASE = eif.busy;
  assign ERASE_TICK = eif.tick;

  // apb: data and error prepared in setup, so no wait states are needed
  assign setup = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PWRITE && !err_ff;
  assign PREADY = 1'b1;
  assign PRDATA = prdata_ff;
  assign PSLVERR = err_ff;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      prdata_ff <= 32'h0;
      err_ff <= 1'b0;
    end else if (setup) begin
      err_ff <= !addr_ok(PADDR);
      prdata_ff <= 32'h0;
      if (!PWRITE && PADDR == REG_TIMING_DIV) begin
        prdata_ff <= {25'h0, timing_div_ff};
      end else if (!PWRITE && PADDR == REG_SEC_STATUS) begin
        prdata_ff[ST_SECURED] <= sec_ff;
        prdata_ff[ST_KEY_EN] <= key_en_ff;
        prdata_ff[ST_BOOT_INT] <= !ext_boot_ff;
        prdata_ff[ST_DBG_DIS] <= sec_ff;
        prdata_ff[ST_REC_BUSY] <= eif.busy;
        prdata_ff[ST_REC_DONE] <= eif.done;
        prdata_ff[ST_BD_OPEN] <= bd_open_ff;
      end
    end
  end

  // software flash timing divider, overridden during recovery
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      timing_div_ff <= TIMING_DIV_RST;
    end else if (wr_acc && PADDR == REG_TIMING_DIV) begin
      timing_div_ff <= PWDATA[6:0];
    end
  end

  // key compare works only when the key enable bit is set
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      bd_open_ff <= 1'b0;
    end else if (wr_acc && PADDR == REG_BACKDOOR && key_en_ff && sec_ff
                 && PWDATA == KEY_WORD) begin
      bd_open_ff <= 1'b1;
    end
  end

  assign BACKDOOR_OPEN = bd_open_ff;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  a_secure_hold: assert property (!sec_sample |=> $stable(sec_ff))
    else $error("security changed outside the sample window");
  a_no_ext_space: assert property (SECURED |-> !EXT_PSPACE_EN && DEBUG_READ_DIS)
    else $error("external space open while secured");
  a_boot_addr: assert property (SECURED |-> BOOT_INTERNAL && BOOT_ADDR == BOOT_FLASH_ADDR)
    else $error("secured part not booting from boot flash");
  a_ext_boot_ign: assert property (sec_sample && is_secured(SEC_BYTE_LO) |=> BOOT_INTERNAL)
    else $error("boot pin honoured while secured");
  a_debug_dis: assert property (sec_sample |=> DEBUG_READ_DIS == $past(is_secured(SEC_BYTE_LO)))
    else $error("debug disable does not follow the bytes");
  a_div_capture: assert property (tck_rise && tap_ff == TAP_UPD_DR && ir_ff == IR_LOCKOUT
    && TRST_B |=> div_valid_ff && div_ff == $past(dr_sh_ff[6:0]))
    else $error("divider not captured on update");
  a_div_override: assert property (rec_active_ff |=> PRESCALE_BY_EIGHT == $past(div_ff[6])
    && FLASH_DIVISOR == $past(div_ff[5:0]))
    else $error("jtag divider not applied");
  a_start_valid: assert property (eif.start |-> div_valid_ff && ir_ff == IR_LOCKOUT)
    else $error("erase started without a divider");
  a_backdoor: assert property ($rose(bd_open_ff) |-> $past(key_en_ff))
    else $error("backdoor opened with key disabled");
  c_secured: cover property (sec_sample ##1 SECURED);
  c_ext_boot: cover property (sec_sample ##1 EXT_PSPACE_EN);
  c_recovery: cover property (eif.start ##[1:1000] MASS_ERASE);
  c_backdoor: cover property ($rose(BACKDOOR_OPEN));
endmodule // fsl_top

// [tb/fsl_jtag_host.sv]
`timescale 1ns/1ps
// debug host bit-banging the tap from the system clock domain
module fsl_jtag_host (
  input wire logic clk,
  output logic trst_b,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // tck parks high between frames, so no rising edge is seen there
  initial begin
    trst_b = 1'b1;
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period, each half two system clocks as the tap sampler needs
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clk);
    tms <= m;
    tdi <= d;
    tck <= 1'b0;
    repeat (2) @(posedge clk);
    q = tdo; // tdo settled since the fall
    tck <= 1'b1;
    @(posedge clk);
  endtask
  // ir or dr scan from idle, lsb first, update then back to idle
  task automatic scan(input logic ir, input logic [31:0] val, input int n,
                      output logic [31:0] got);
    logic q;
    got = '0;
    step(1'b1, ~val[0], q);
    if (ir) step(1'b1, ~val[0], q);
    step(1'b0, ~val[0], q);
    step(1'b0, ~val[0], q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, val[i], q);
      got[i] = q;
    end
    step(1'b1, ~val[n-1], q); // tdi toggles so a stale bit is never reused
    step(1'b0, ~val[n-1], q);
  endtask
  // trst pulse, then walk to run-test/idle
  task automatic tap_reset();
    logic q;
    @(posedge clk);
    trst_b <= 1'b0;
    repeat (4) @(posedge clk);
    trst_b <= 1'b1;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule // fsl_jtag_host

// [tb/fsl_top_test.sv]
`timescale 1ns/1ps
module fsl_top_test;
  import fsl_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, ebs;
  logic [11:0] paddr;
  logic [31:0] pwdata, key, rd;
  logic [7:0] slo, shi, bscan;
  logic [31:0] prdata;
  logic pready, pslverr, tdo, tdo_oe, secured, boot_int, ext_en, dbg_dis, bd_open;
  logic periph_run, core_run, pre8, erase, tick, trst_b, tck, tms, tdi, err;
  logic [23:0] boot_addr;
  logic [5:0] fdiv;
  int failures, checked, cycles;
  fsl_top #(.ERASE_EVENTS(4)) i_fsl_top (.CLOCK(clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SEC_BYTE_LO(slo), .SEC_BYTE_HI(shi),
    .KEY_WORD(key), .EXTERNAL_BOOT_SELECT(ebs), .TRST_B(trst_b), .TCK(tck), .TMS(tms),
    .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .BSCAN_IN(bscan), .SECURED(secured),
    .BOOT_INTERNAL(boot_int), .BOOT_ADDR(boot_addr), .EXT_PSPACE_EN(ext_en),
    .DEBUG_READ_DIS(dbg_dis), .BACKDOOR_OPEN(bd_open), .PERIPH_RUN(periph_run),
    .CORE_RUN(core_run), .PRESCALE_BY_EIGHT(pre8), .FLASH_DIVISOR(fdiv),
    .MASS_ERASE(erase), .ERASE_TICK(tick));
  fsl_jtag_host i_fsl_jtag_host (.clk(clk), .trst_b(trst_b), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // apb transfer, request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk); // outputs launched by the access edge have settled here
  endtask
  // chip reset with given security bytes; waits for the core release
  task automatic do_reset(input logic [7:0] lo, input logic [7:0] hi, input logic sec);
    int n;
    slo <= lo;
    shi <= hi;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    n = 0;
    while (periph_run !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk); // bytes are taken in the first cycle of the peripheral window
    chk("secured at periph release", sec, secured);
    while (core_run !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("core_run", 1, core_run);
  endtask
  task automatic t_secured();
    do_reset(8'h5a, 8'h80, 1'b1);
    chk("boot_internal", 1, boot_int);
    chk("boot_addr", 32'h020000, boot_addr);
    chk("ext_pspace_en", 0, ext_en);
    chk("debug_read_dis", 1, dbg_dis);
    apb(1'b0, REG_SEC_STATUS, 0);
    chk("status", 32'h0000000f, rd);
    apb(1'b0, 12'h00c, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
  endtask
  task automatic t_idcode();
    logic [31:0] got;
    i_fsl_jtag_host.tap_reset();
    i_fsl_jtag_host.scan(1'b0, 32'h0, 32, got);
    chk("idcode", ID_CODE, got);
    chk("tdo_oe idle", 0, tdo_oe);
    i_fsl_jtag_host.scan(1'b1, IR_SAMPLE, 4, got);
    i_fsl_jtag_host.scan(1'b0, 32'h0, 8, got);
    chk("sample", 32'h000000a5, got);
  endtask
  task automatic t_refused();
    logic q;
    logic [31:0] got;
    apb(1'b1, REG_TIMING_DIV, 32'h13);
    repeat (2) @(posedge clk);
    chk("divisor reg", 32'h13, fdiv);
    chk("prescale reg", 0, pre8);
    apb(1'b0, REG_TIMING_DIV, 0);
    chk("divider readback", 32'h13, rd);
    // the second scan enters idle with the recovery instruction but no divider
    repeat (2) i_fsl_jtag_host.scan(1'b1, IR_LOCKOUT, 4, got);
    repeat (3) i_fsl_jtag_host.step(1'b0, 1'b0, q);
    chk("no erase without divider", 0, erase);
  endtask
  task automatic t_recovery();
    logic [31:0] got;
    int n, ticks, t1, gap;
    i_fsl_jtag_host.scan(1'b1, IR_LOCKOUT, 4, got);
    chk("ir capture", 32'h1, got);
    i_fsl_jtag_host.scan(1'b0, 32'h5f, 7, got); // 195 khz from 50 mhz
    n = 0;
    while (erase !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("mass_erase start", 1, erase);
    chk("prescale override", 1, pre8);
    chk("divisor override", 32'h1f, fdiv);
    ticks = 0;
    t1 = 0;
    gap = 0;
    // host stays in idle with tck parked for the whole erase
    while (erase === 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
      if (tick === 1'b1) begin
        ticks++;
        if (ticks == 1) t1 = n;
        if (ticks == 2) gap = n - t1;
      end
    end
    chk("erase events", 4, ticks);
    chk("tick spacing", 2 * 8 * 32, gap);
    apb(1'b0, REG_SEC_STATUS, 0);
    chk("status done", 32'h0000002f, rd);
  endtask
  task automatic t_backdoor();
    apb(1'b1, REG_BACKDOOR, key ^ 32'h1);
    chk("backdoor wrong key", 0, bd_open);
    apb(1'b1, REG_BACKDOOR, key);
    chk("backdoor key", 1, bd_open);
    apb(1'b0, REG_SEC_STATUS, 0);
    chk("status open", 32'h0000006f, rd);
  endtask
  task automatic t_unsecured();
    i_fsl_jtag_host.tap_reset();
    do_reset(8'hff, 8'hff, 1'b0);
    chk("boot_internal", 0, boot_int);
    chk("boot_addr", 0, boot_addr);
    chk("ext_pspace_en", 1, ext_en);
    chk("debug_read_dis", 0, dbg_dis);
    chk("backdoor cleared", 0, bd_open);
    chk("divisor restored", 0, fdiv);
    apb(1'b0, REG_SEC_STATUS, 0);
    chk("status clear", 32'h00000002, rd); // erased bytes keep key enable
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a hang is cut short well past the expected few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    key = 32'h3c5a0f96; // key is in place before the security bytes
    ebs = 1'b1;
    slo = 8'h5a;
    shi = 8'h80;
    bscan = 8'ha5;
    failures = 0;
    checked = 0;
    cycles = 0;
    t_secured();
    t_idcode();
    t_refused();
    t_recovery();
    t_backdoor();
    t_unsecured();
    finish_test();
  end
endmodule // fsl_top_test
